// >>> design/rtcf_top.sv
// Health flags, supply sampling and interrupt merge with APB registers
`timescale 1ns/10ps
module rtcf_top #(
  parameter int SAMPLE_CYC = rtcf_pkg::SAMPLE_CYC
) (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Time base events and analog inputs
  input  wire rtcf_pkg::rtcf_events_s events,
  input  wire logic                 osc_clk_in,
  input  wire logic                 supply_below_hi,
  input  wire logic                 supply_below_lo,
  // Outputs
  output logic                      interrupt_out_n,
  output logic                      sampling_active
);
  logic [7:0]  ctrl1;
  logic [7:0]  ctrl2;
  logic [7:0]  adjust;
  logic [7:0]  next_ctrl1;
  logic [7:0]  next_ctrl2;
  logic [7:0]  next_adjust;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic [31:0] sec_cnt;
  logic [31:0] next_sec_cnt;
  logic        next_sampling;
  logic        next_int_n;
  logic        osc_s1;
  logic        osc_s2;
  logic        hi_s1;
  logic        hi_s2;
  logic        lo_s1;
  logic        lo_s2;
  logic        halt_pulse;
  logic        pulse_wave;
  logic        next_pulse_wave;
  logic        wr;
  logic        rd;
  logic        below;
  logic        periodic_event;
  logic        per_low;
  logic [2:0]  sel;

  rtcf_osc_watch u_osc_watch (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .osc_sync   (osc_s2),
    .halt_pulse (halt_pulse)
  );

  // Pin synchronisers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      hi_s1  <= 1'b0;
      hi_s2  <= 1'b0;
      lo_s1  <= 1'b0;
      lo_s2  <= 1'b0;
    end else begin
      osc_s1 <= osc_clk_in;
      osc_s2 <= osc_s1;
      hi_s1  <= supply_below_hi;
      hi_s2  <= hi_s1;
      lo_s1  <= supply_below_lo;
      lo_s2  <= lo_s1;
    end
  end

  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] r);
    addr_is = (a == r);
  endfunction : addr_is

  assign wr  = psel && penable && pwrite && pready;
  assign rd  = psel && !penable && !pwrite;
  assign sel = ctrl1[rtcf_pkg::C1_SEL_HI:0];
  assign below = ctrl2[7] ? lo_s2 : hi_s2; // RULE3

  // Periodic source event selection
  always_comb begin
    periodic_event = 1'b0;
    unique case (sel[1:0])
      2'h0: periodic_event = events.sec_tick;
      2'h1: periodic_event = events.min_tick;
      2'h2: periodic_event = events.hour_tick;
      2'h3: periodic_event = events.month_tick;
    endcase
  end

  // Pulse mode square wave
  always_comb begin
    next_pulse_wave = pulse_wave;
    if (sel == rtcf_pkg::SEL_2HZ && events.half_tick) begin
      next_pulse_wave = !pulse_wave; // RULE13
    end else if (sel == rtcf_pkg::SEL_1HZ && events.sec_tick) begin
      next_pulse_wave = !pulse_wave; // RULE13
    end else if (sel[2] || sel[1] == 1'b0) begin
      next_pulse_wave = 1'b0;
    end
  end

  assign per_low = (sel == rtcf_pkg::SEL_LOW) || (sel[2:1] == 2'b01 && pulse_wave)
                   || (sel[2] && ctrl2[rtcf_pkg::C2_PER]);

  // Register file and flags
  always_comb begin
    next_ctrl1  = ctrl1;
    next_ctrl2  = ctrl2;
    next_adjust = adjust;
    if (wr && addr_is(paddr, rtcf_pkg::ADDR_CTRL1)) begin
      next_ctrl1 = pwdata[7:0];
    end
    if (wr && addr_is(paddr, rtcf_pkg::ADDR_ADJUST)) begin
      next_adjust = pwdata[7:0];
    end
    if (wr && addr_is(paddr, rtcf_pkg::ADDR_CTRL2)) begin
      next_ctrl2[7] = pwdata[7];
      next_ctrl2[3] = pwdata[3];
      next_ctrl2[rtcf_pkg::C2_OSC_N] = pwdata[rtcf_pkg::C2_OSC_N]; // RULE5
      // Flags: zero clears, one ignored
      if (!pwdata[rtcf_pkg::C2_PON])  next_ctrl2[rtcf_pkg::C2_PON]  = 1'b0; // RULE5
      if (!pwdata[rtcf_pkg::C2_LOWV]) next_ctrl2[rtcf_pkg::C2_LOWV] = 1'b0; // RULE5
      if (!pwdata[rtcf_pkg::C2_PER])  next_ctrl2[rtcf_pkg::C2_PER]  = 1'b0; // RULE19
      if (!pwdata[rtcf_pkg::C2_WEEK]) next_ctrl2[rtcf_pkg::C2_WEEK] = 1'b0; // RULE18
      if (!pwdata[rtcf_pkg::C2_DAY])  next_ctrl2[rtcf_pkg::C2_DAY]  = 1'b0; // RULE18
    end
    // Hardware sets and the halt clear win over software writes; the pulse-mode periodic clear yields to any write
    if (halt_pulse) next_ctrl2[rtcf_pkg::C2_OSC_N] = 1'b0; // RULE2
    if (sampling_active && below) next_ctrl2[rtcf_pkg::C2_LOWV] = 1'b1; // RULE4
    if (ctrl1[rtcf_pkg::C1_WEEK_EN] && events.week_match) begin
      next_ctrl2[rtcf_pkg::C2_WEEK] = 1'b1; // RULE12
    end
    if (ctrl1[rtcf_pkg::C1_DAY_EN] && events.day_match) begin
      next_ctrl2[rtcf_pkg::C2_DAY] = 1'b1; // RULE12
    end
    if (sel[2] && periodic_event) next_ctrl2[rtcf_pkg::C2_PER] = 1'b1; // RULE19
    if (sel[2:1] == 2'b01 && pulse_wave) next_ctrl2[rtcf_pkg::C2_PER] = 1'b1;
    if (sel[2:1] == 2'b01 && !pulse_wave && !wr) next_ctrl2[rtcf_pkg::C2_PER] = 1'b0;
    // Power-on flag holds configuration and flags at zero, except the running flag
    if (next_ctrl2[rtcf_pkg::C2_PON]) begin
      next_ctrl1  = rtcf_pkg::REG_RESET; // RULE7
      next_adjust = rtcf_pkg::REG_RESET; // RULE7
      next_ctrl2  = next_ctrl2 & 8'h30;  // RULE7
    end
  end

  // Supply sampling window, one per second
  always_comb begin
    next_sec_cnt  = sec_cnt;
    next_sampling = 1'b0;
    if (events.sec_tick) begin
      next_sec_cnt = 32'h0000_0000;
    end else if (sec_cnt != 32'(SAMPLE_CYC)) begin
      next_sec_cnt = sec_cnt + 32'h0000_0001;
    end
    // RULE9 RULE10
    next_sampling = (next_sec_cnt < 32'(SAMPLE_CYC)) && !next_ctrl2[rtcf_pkg::C2_LOWV];
  end

  // Interrupt merge of active-low requests
  always_comb begin
    next_int_n = !(ctrl2[rtcf_pkg::C2_WEEK] || ctrl2[rtcf_pkg::C2_DAY] || per_low); // RULE16
  end

  // APB answer: reads one access cycle, zero wait states
  always_comb begin
    next_prdata  = 32'h0000_0000;
    next_pready  = psel && !penable;
    next_pslverr = 1'b0;
    if (psel && !penable) begin
      if (addr_is(paddr, rtcf_pkg::ADDR_CTRL1)) begin
        next_prdata = {24'h00_0000, ctrl1};
      end else if (addr_is(paddr, rtcf_pkg::ADDR_CTRL2)) begin
        next_prdata = {24'h00_0000, ctrl2}; // RULE14
      end else if (addr_is(paddr, rtcf_pkg::ADDR_ADJUST)) begin
        next_prdata = {24'h00_0000, adjust};
      end else begin
        next_pslverr = 1'b1;
      end
      if (!rd) next_prdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl1           <= rtcf_pkg::REG_RESET; // RULE1
      adjust          <= rtcf_pkg::REG_RESET; // RULE1
      ctrl2           <= rtcf_pkg::C2_RESET;  // RULE6
      sec_cnt         <= 32'h0000_0000;
      sampling_active <= 1'b0;
      pulse_wave      <= 1'b0;
      interrupt_out_n <= 1'b1; // RULE15
      prdata          <= 32'h0000_0000;
      pready          <= 1'b0;
      pslverr         <= 1'b0;
    end else begin
      ctrl1           <= next_ctrl1;
      adjust          <= next_adjust;
      ctrl2           <= next_ctrl2;
      sec_cnt         <= next_sec_cnt;
      sampling_active <= next_sampling;
      pulse_wave      <= next_pulse_wave;
      interrupt_out_n <= next_int_n;
      prdata          <= next_prdata;
      pready          <= next_pready;
      pslverr         <= next_pslverr;
    end
  end

  AST_PON_HOLDS_CTRL1: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ctrl2[rtcf_pkg::C2_PON] |-> ctrl1 == 8'h00 && adjust == 8'h00) // RULE7
    else $error("control bits not held while power-on flag set");
  AST_PON_HOLDS_FLAGS: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ctrl2[rtcf_pkg::C2_PON] |-> (ctrl2 & 8'hCF) == 8'h00) // RULE7
    else $error("flags not held while power-on flag set");
  AST_PON_ONE_IGNORED: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !ctrl2[rtcf_pkg::C2_PON] |=> !ctrl2[rtcf_pkg::C2_PON]) // RULE5
    else $error("power-on flag set again after clear");
  AST_HALT_CLEARS_OSC: assert property (@(posedge clk_sys) disable iff (!rst_n)
    halt_pulse |=> !ctrl2[rtcf_pkg::C2_OSC_N]) // RULE2
    else $error("halt did not clear running flag");
  AST_LOWV_STOPS_SAMPLING: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ctrl2[rtcf_pkg::C2_LOWV] |-> !sampling_active) // RULE10
    else $error("sampling while low-voltage flag set");
  AST_LOWV_SET: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sampling_active && below && !ctrl2[rtcf_pkg::C2_PON] |=> ctrl2[rtcf_pkg::C2_LOWV]) // RULE3
    else $error("low supply not recorded");
  AST_SAMPLE_WINDOW: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sampling_active |-> sec_cnt < 32'(SAMPLE_CYC)) // RULE9
    else $error("sampling outside window");
  AST_ALARM_DRIVES_LOW: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ctrl1[rtcf_pkg::C1_DAY_EN] && events.day_match && !ctrl2[rtcf_pkg::C2_PON]
    |=> ##1 !interrupt_out_n) // RULE12
    else $error("alarm match did not drive interrupt");
  AST_IDLE_HIGH: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ctrl2[rtcf_pkg::C2_PON] && $past(ctrl2[rtcf_pkg::C2_PON]) |=> interrupt_out_n) // RULE15
    else $error("interrupt active with sources disabled");
  AST_LEVEL_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sel[2] && ctrl2[rtcf_pkg::C2_PER] |=> !interrupt_out_n) // RULE19
    else $error("level mode request not driven");
  COV_ALARM: cover property (@(posedge clk_sys) disable iff (!rst_n)
    ctrl2[rtcf_pkg::C2_WEEK] ##1 !ctrl2[rtcf_pkg::C2_WEEK]);
  COV_LOWV: cover property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(ctrl2[rtcf_pkg::C2_LOWV]));
  COV_HALT: cover property (@(posedge clk_sys) disable iff (!rst_n) halt_pulse);
endmodule : rtcf_top

// >>> design/rtcf_pkg.sv
// Package with register map, field positions and timing constants for the RTC health block
// Functional notes
// RULE1: Power-on clears both control registers and adjustment; code loads control register two with 0x10
// RULE2: Oscillator halt drives running flag to zero
// RULE3: Threshold select picks 1.6 V or 1.3 V
// RULE4: Power-on, low-voltage high active; running flag low
// RULE5: Only zero writes clear power-on, low-voltage flags
// RULE6: Power-up sets power-on one, low-voltage zero
// RULE7: Power-on flag holds listed control bits at zero
// RULE8: Host reads three health flags together
// RULE9: Supply sampled 7.8 ms each second only
// RULE10: Set low-voltage flag stops further sampling
// RULE11: Host clears low-voltage flag after seconds write
// RULE12: Alarm match drives interrupt low
// RULE13: Periodic select gives pulse or level mode
// RULE14: Flags at 0xF, enables at 0xE bit layout
// RULE15: Reset enables keep interrupt output high
// RULE16: Interrupt output is OR of low requests
// RULE17: Host reads flags to find interrupt source
// RULE18: Zero to alarm flag releases its drive
// RULE19: Level mode holds low until flag cleared
// RULE20: No oscillator edge within timeout clears running flag
package rtcf_pkg;

  // Register indices; byte address is four times the index
  localparam logic [3:0]  IDX_CTRL1      = 4'hE;
  localparam logic [3:0]  IDX_CTRL2      = 4'hF;
  localparam logic [3:0]  IDX_ADJUST     = 4'h7;
  localparam logic [11:0] ADDR_CTRL1     = {6'h00, IDX_CTRL1, 2'h0};
  localparam logic [11:0] ADDR_CTRL2     = {6'h00, IDX_CTRL2, 2'h0};
  localparam logic [11:0] ADDR_ADJUST    = {6'h00, IDX_ADJUST, 2'h0};

  // Control register one fields
  localparam int C1_WEEK_EN  = 7;
  localparam int C1_DAY_EN   = 6;
  localparam int C1_SEL_HI   = 2;
  // Control register two fields
  localparam int C2_LOWV     = 6;
  localparam int C2_OSC_N    = 5;
  localparam int C2_PON      = 4;
  localparam int C2_PER      = 2;
  localparam int C2_WEEK     = 1;
  localparam int C2_DAY      = 0;
  localparam logic [7:0] C2_RESET   = 8'h10;
  localparam logic [7:0] REG_RESET  = 8'h00;

  // Periodic select codes
  localparam logic [2:0] SEL_OFF    = 3'h0;
  localparam logic [2:0] SEL_LOW    = 3'h1;
  localparam logic [2:0] SEL_2HZ    = 3'h2;
  localparam logic [2:0] SEL_1HZ    = 3'h3;

  // Timing at 250 MHz
  localparam int CLK_MHZ        = 250;
  localparam int SAMPLE_US      = 7800;
  localparam int SAMPLE_CYC     = SAMPLE_US * CLK_MHZ;
  localparam int OSC_TIMEOUT_NS = 1000;
  localparam int OSC_TIMEOUT_CYC = (OSC_TIMEOUT_NS * CLK_MHZ) / 1000;

  typedef struct packed {
    logic week_match;
    logic day_match;
    logic sec_tick;
    logic half_tick;
    logic min_tick;
    logic hour_tick;
    logic month_tick;
  } rtcf_events_s;

endpackage : rtcf_pkg

// >>> design/rtcf_osc_watch.sv
// Oscillator halt watchdog on the system reference clock
`timescale 1ns/10ps
module rtcf_osc_watch (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Oscillator sample, already synchronised
  input  wire logic osc_sync,
  // Halt event pulse
  output logic      halt_pulse
);
  logic [15:0] cnt;
  logic        osc_d;
  logic        next_halt;
  logic [15:0] next_cnt;

  always_comb begin
    next_cnt  = cnt;
    next_halt = 1'b0;
    if (osc_sync != osc_d) begin
      next_cnt = 16'h0000;
    end else if (cnt == 16'(rtcf_pkg::OSC_TIMEOUT_CYC)) begin
      next_halt = 1'b1; // RULE20
      next_cnt  = 16'h0000;
    end else begin
      next_cnt = cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt        <= 16'h0000;
      osc_d      <= 1'b0;
      halt_pulse <= 1'b0;
    end else begin
      cnt        <= next_cnt;
      osc_d      <= osc_sync;
      halt_pulse <= next_halt;
    end
  end

  AST_HALT_NEEDS_QUIET: assert property (@(posedge clk_sys) disable iff (!rst_n)
    halt_pulse |-> $past(osc_sync) == $past(osc_sync, 2)) // RULE20
    else $error("halt reported right after an oscillator edge");
endmodule : rtcf_osc_watch

// >>> bench/rtcf_host.sv
// Host CPU model: APB master that reads and writes the control registers
`timescale 1ns/10ps
module rtcf_host (
  // Clock
  input  wire logic        clk_sys,
  // APB master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  logic hang;

  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    hang    = 1'b0;
  end

  // Entered right after a rising edge; the flag word is always read whole
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rq, output logic re);
    int   n;
    logic done;
    n = 0;
    done = 1'b0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Answer is taken at the rising edge that samples pready high, before it updates
    while (!done && n < 16) begin
      @(posedge clk_sys);
      n++;
      if (pready === 1'b1) begin
        rq = prdata;
        re = pslverr;
        done = 1'b1;
      end
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    hang = !done;
    @(posedge clk_sys);
  endtask : xfer
endmodule : rtcf_host

// >>> bench/rtcf_top_tb.sv
// Self-checking bench for the health flag and interrupt merge block
`timescale 1ns/10ps
module rtcf_top_tb;
  localparam int          SCYC = 50;
  localparam logic [11:0] A1   = rtcf_pkg::ADDR_CTRL1;
  localparam logic [11:0] A2   = rtcf_pkg::ADDR_CTRL2;
  localparam logic [11:0] AJ   = rtcf_pkg::ADDR_ADJUST;
  logic                   clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0]            paddr;
  logic [31:0]            pwdata, prdata, q, lfsr;
  rtcf_pkg::rtcf_events_s events;
  logic                   osc_clk_in, osc_en, below_hi, below_lo, int_n, samp;
  logic [2:0]             osc_cnt;
  int                     num_errors, cmp_count, n, k, tog;
  int                     lvl_k[4] = '{2, 4, 5, 6};

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // Crystal stand-in, halted by osc_en
  always @(posedge clk_sys) begin
    osc_cnt <= osc_cnt + 3'h1;
    if (osc_en && osc_cnt == 3'h0) osc_clk_in <= ~osc_clk_in;
  end
  always @(int_n) tog++;

  rtcf_top #(.SAMPLE_CYC(SCYC)) i_rtcf_top (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .events(events), .osc_clk_in(osc_clk_in),
    .supply_below_hi(below_hi), .supply_below_lo(below_lo), .interrupt_out_n(int_n),
    .sampling_active(samp));
  rtcf_host i_rtcf_host (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    next_rand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_rand

  // Flag word from {threshold, low voltage, osc running, periodic, weekly, daily}
  function automatic logic [7:0] f2(input logic [5:0] v);
    f2 = 8'h00;
    f2[7] = v[5];
    f2[rtcf_pkg::C2_LOWV] = v[4];
    f2[rtcf_pkg::C2_OSC_N] = v[3];
    f2[rtcf_pkg::C2_PER] = v[2];
    f2[rtcf_pkg::C2_WEEK] = v[1];
    f2[rtcf_pkg::C2_DAY] = v[0];
  endfunction : f2

  task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask : check_word

  task automatic check_bit(input string name, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected %s expected %b seen %b", name, exp, got);
      num_errors++;
    end
  endtask : check_bit

  task automatic end_of_test();
    $display("comparisons %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d);
    i_rtcf_host.xfer(w, a, d, q, e);
    if (i_rtcf_host.hang) begin
      num_errors++;
      end_of_test();
    end
  endtask : xf

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xf(1'b1, a, {24'h0, d});
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    xf(1'b0, a, 32'h0);
    check_word($sformatf("register %h", a), {24'h0, exp}, q);
  endtask : rd

  task automatic fire(input int idx);
    events <= rtcf_pkg::rtcf_events_s'(7'h40 >> idx);
    @(posedge clk_sys);
    events <= '0;
  endtask : fire

  task automatic wait_int(input logic exp);
    int i;
    i = 0;
    do begin
      @(negedge clk_sys);
      i++;
    end while (int_n !== exp && i < 8);
    check_bit("interrupt_out_n", exp, int_n);
    if (int_n !== exp) end_of_test();
    @(posedge clk_sys);
  endtask : wait_int

  // One seconds tick, then count the cycles the supply sampler is on
  task automatic window(output int cnt);
    cnt = 0;
    fire(2);
    repeat (SCYC + 20) begin
      @(negedge clk_sys);
      if (samp === 1'b1) cnt++;
    end
    @(posedge clk_sys);
  endtask : window

  initial begin
    rst_n = 1'b0;
    events = '0;
    osc_en = 1'b1;
    osc_clk_in = 1'b0;
    osc_cnt = 3'h0;
    below_hi = 1'b0;
    below_lo = 1'b0;
    num_errors = 0;
    cmp_count = 0;
    lfsr = 32'h50F3;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    wait_int(1'b1);
    rd(A1, 8'h00);
    rd(AJ, 8'h00);
    rd(A2, rtcf_pkg::C2_RESET);
    wr(A1, 8'hC7);
    rd(A1, 8'h00);
    wr(AJ, 8'hFF);
    rd(AJ, 8'h00);
    wr(A2, 8'hFF);
    rd(A2, f2(6'b001000) | rtcf_pkg::C2_RESET);
    wr(A2, f2(6'b001000));
    rd(A2, f2(6'b001000));
    wr(A2, f2(6'b011111));
    rd(A2, f2(6'b001000));
    xf(1'b0, 12'h000, 32'h0);
    check_bit("pslverr", 1'b1, e);
    check_word("unmapped read", 32'h0, q);
    for (k = 0; k < 4; k++) begin
      lfsr = next_rand(lfsr);
      wr(AJ, lfsr[7:0]);
      rd(AJ, lfsr[7:0]);
    end
    osc_en <= 1'b0;
    repeat (300) @(posedge clk_sys);
    rd(A2, f2(6'b000000));
    osc_en <= 1'b1;
    wr(A2, f2(6'b001000));
    repeat (300) @(posedge clk_sys);
    rd(A2, f2(6'b001000));
    window(n);
    check_word("sample cycles", SCYC, n);
    below_hi <= 1'b1;
    window(n);
    rd(A2, f2(6'b011000));
    window(n);
    check_word("sample cycles", 32'h0, n);
    wr(A2, f2(6'b101000));
    window(n);
    rd(A2, f2(6'b101000));
    below_lo <= 1'b1;
    window(n);
    rd(A2, f2(6'b111000));
    below_hi <= 1'b0;
    below_lo <= 1'b0;
    wr(A2, f2(6'b001000));
    wr(A1, 8'hC0);
    fire(0);
    wait_int(1'b0);
    rd(A2, f2(6'b001010));
    fire(1);
    repeat (3) @(posedge clk_sys);
    rd(A2, f2(6'b001011));
    wr(A2, f2(6'b001001));
    wait_int(1'b0);
    wr(A2, f2(6'b001000));
    wait_int(1'b1);
    fire(0);
    wait_int(1'b0);
    wr(A2, f2(6'b001000));
    wait_int(1'b1);
    for (k = 4; k < 8; k++) begin
      wr(A1, k[7:0]);
      fire(lvl_k[k-4]);
      wait_int(1'b0);
      repeat (20) @(posedge clk_sys);
      rd(A2, f2(6'b001100));
      wait_int(1'b0);
      wr(A2, f2(6'b001000));
      wait_int(1'b1);
    end
    wr(A1, {5'h00, rtcf_pkg::SEL_LOW});
    wait_int(1'b0);
    wr(A1, 8'h00);
    wr(A2, f2(6'b001000));
    wait_int(1'b1);
    for (k = 2; k < 4; k++) begin
      wr(A1, k[7:0]);
      tog = 0;
      repeat (6) begin
        lfsr = next_rand(lfsr);
        repeat (int'(lfsr[3:0]) + 2) @(posedge clk_sys);
        fire(3);
        repeat (int'(lfsr[7:4]) + 2) @(posedge clk_sys);
        fire(2);
      end
      repeat (4) @(posedge clk_sys);
      check_word("pulse wave toggles", 32'h0000_0006, tog);
      wr(A1, 8'h00);
      wr(A2, f2(6'b001000));
      wait_int(1'b1);
    end
    wr(A1, 8'hC0);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd(A1, 8'h00);
    rd(A2, rtcf_pkg::C2_RESET);
    end_of_test();
  end
endmodule : rtcf_top_tb
